//--- hw/addr_mode_pkg.sv
// Shared types and constants of the operand addressing unit.
// Assumes one clock domain shared with the CPU bus and the opcode decoder.
package addr_mode_pkg;

  // ==========================================================
  // Addressing modes as delivered by the opcode decoder
  typedef enum logic [3:0] {
    mode_inherent,
    mode_immediate,
    mode_dir_short,
    mode_dir_long,
    mode_idx_none,
    mode_idx_short,
    mode_idx_long,
    mode_ind_short,
    mode_ind_long,
    mode_indidx_short,
    mode_indidx_long,
    mode_rel_direct,
    mode_rel_indirect,
    mode_bit_direct,
    mode_bit_indirect,
    mode_bit_dir_rel
  } addr_mode_t;

  // ==========================================================
  // Prefix byte values
  localparam logic [7:0] index_swap_prefix          = 8'h90;
  localparam logic [7:0] indirect_index_swap_prefix = 8'h91;
  localparam logic [7:0] indirect_conversion_prefix = 8'h92;

  localparam logic [15:0] addr_step   = 16'h0001;
  localparam logic [7:0]  page_zero_hi = 8'h00;

  // ==========================================================
  // Request and result carriers
  typedef struct packed {
    addr_mode_t  mode;
    logic [7:0]  prefix;
    logic        prefix_valid;
    logic        rmw;
    logic [15:0] program_counter;
    logic [7:0]  index_x;
    logic [7:0]  index_y;
  } addr_req_t;

  typedef struct packed {
    logic [15:0] ea;
    logic [15:0] target;
    logic [7:0]  operand;
    logic [1:0]  length;
    logic        refused;
  } addr_res_t;

  // ==========================================================
  // Per-mode properties
  function automatic logic [1:0] arg_bytes(input addr_mode_t m);
    case (m)
      mode_inherent, mode_idx_none: arg_bytes = 2'd0;
      mode_dir_long, mode_idx_long: arg_bytes = 2'd2;
      default:                      arg_bytes = 2'd1;
    endcase
  endfunction

  function automatic logic [1:0] ptr_bytes(input addr_mode_t m);
    case (m)
      mode_ind_short, mode_indidx_short, mode_rel_indirect, mode_bit_indirect: ptr_bytes = 2'd1;
      mode_ind_long, mode_indidx_long:                                         ptr_bytes = 2'd2;
      default:                                                                 ptr_bytes = 2'd0;
    endcase
  endfunction

  function automatic logic has_disp(input addr_mode_t m);
    has_disp = (m == mode_bit_dir_rel);
  endfunction

  function automatic logic is_indexed(input addr_mode_t m);
    case (m)
      mode_idx_none, mode_idx_short, mode_idx_long,
      mode_indidx_short, mode_indidx_long: is_indexed = 1'b1;
      default:                             is_indexed = 1'b0;
    endcase
  endfunction

  function automatic logic is_long(input addr_mode_t m);
    case (m)
      mode_dir_long, mode_idx_long, mode_ind_long, mode_indidx_long: is_long = 1'b1;
      default:                                                       is_long = 1'b0;
    endcase
  endfunction

endpackage

//--- hw/addr_prefix_map.sv
// Applies a prefix byte to the decoded mode and picks the index register.
// Assumes the prefix and mode are stable while the request is presented.
`timescale 1ns/10ps

module addr_prefix_map (
  input  wire addr_mode_pkg::addr_mode_t base_mode,
  input  wire logic [7:0]                prefix,
  input  wire logic                      prefix_valid,
  output addr_mode_pkg::addr_mode_t      eff_mode,
  output logic                           use_y
);

  // ==========================================================
  // Prefix translation
  always_comb begin
    eff_mode = base_mode;
    use_y    = 1'b0;
    if (prefix_valid) begin
      if (prefix == addr_mode_pkg::index_swap_prefix) begin
        use_y = 1'b1;
      end else if (prefix == addr_mode_pkg::indirect_conversion_prefix) begin
        case (base_mode)
          addr_mode_pkg::mode_dir_short:   eff_mode = addr_mode_pkg::mode_ind_short;
          addr_mode_pkg::mode_dir_long:    eff_mode = addr_mode_pkg::mode_ind_long;
          addr_mode_pkg::mode_idx_short:   eff_mode = addr_mode_pkg::mode_indidx_short;
          addr_mode_pkg::mode_idx_long:    eff_mode = addr_mode_pkg::mode_indidx_long;
          addr_mode_pkg::mode_rel_direct:  eff_mode = addr_mode_pkg::mode_rel_indirect;
          addr_mode_pkg::mode_bit_direct:  eff_mode = addr_mode_pkg::mode_bit_indirect;
          default:                         eff_mode = base_mode;
        endcase
      end else if (prefix == addr_mode_pkg::indirect_index_swap_prefix) begin
        case (base_mode)
          addr_mode_pkg::mode_idx_short: begin
            eff_mode = addr_mode_pkg::mode_indidx_short;
            use_y    = 1'b1;
          end
          addr_mode_pkg::mode_idx_long: begin
            eff_mode = addr_mode_pkg::mode_indidx_long;
            use_y    = 1'b1;
          end
          default: eff_mode = base_mode;
        endcase
      end
    end
  end

endmodule

//--- hw/addr_mode_unit.sv
// Operand addressing unit: fetches operand bytes and pointers, forms the address.
// Assumes a same-clock memory port: request held until a one-cycle acknowledge.
`timescale 1ns/10ps

module addr_mode_unit (
  input  wire logic                     clk,
  input  wire logic                     resetn,
  input  wire logic                     start,
  input  wire addr_mode_pkg::addr_req_t req,
  output logic                          busy,
  output logic                          done,
  output addr_mode_pkg::addr_res_t      res,
  output logic                          mem_req,
  output logic [15:0]                   mem_addr,
  input  wire logic [7:0]               mem_rdata,
  input  wire logic                     mem_ack
);

  // ==========================================================
  // State
  typedef enum logic [2:0] {
    st_idle,
    st_arg,
    st_ptr,
    st_disp,
    st_done
  } phase_t;

  typedef struct packed {
    phase_t                    phase;
    addr_mode_pkg::addr_mode_t mode;
    logic [15:0]               pc;
    logic [7:0]                idx;
    logic [1:0]                cnt;
    logic [15:0]               arg;
    logic [15:0]               ptr;
    logic [7:0]                disp;
    logic                      mem_req;
    logic [15:0]               mem_addr;
    logic                      busy;
    logic                      done;
    addr_mode_pkg::addr_res_t  res;
  } unit_state_t;

  unit_state_t s;
  unit_state_t next_s;

  addr_mode_pkg::addr_mode_t mapped_mode;
  logic                      mapped_use_y;

  addr_prefix_map u_prefix (
    .base_mode    (req.mode),
    .prefix       (req.prefix),
    .prefix_valid (req.prefix_valid),
    .eff_mode     (mapped_mode),
    .use_y        (mapped_use_y)
  );

  // ==========================================================
  // Address arithmetic
  logic [1:0]  n_arg;
  logic [1:0]  n_ptr;
  logic [1:0]  total_len;
  logic [15:0] base;
  logic [15:0] index_term;
  logic [15:0] next_pc;
  logic [7:0]  rel_byte;
  logic [15:0] after_arg;
  logic        with_disp;
  logic        with_index;

  // ==========================================================
  // Fetch plan of the captured mode
  always_comb begin
    n_arg      = 2'd1;
    n_ptr      = 2'd0;
    with_disp  = 1'b0;
    with_index = 1'b0;
    case (s.mode)
      addr_mode_pkg::mode_inherent: begin
        n_arg = 2'd0;
      end
      addr_mode_pkg::mode_immediate: begin
        n_arg = 2'd1;
      end
      addr_mode_pkg::mode_dir_short: begin
        n_arg = 2'd1;
      end
      addr_mode_pkg::mode_dir_long: begin
        n_arg = 2'd2;
      end
      addr_mode_pkg::mode_idx_none: begin
        n_arg      = 2'd0;
        with_index = 1'b1;
      end
      addr_mode_pkg::mode_idx_short: begin
        with_index = 1'b1;
      end
      addr_mode_pkg::mode_idx_long: begin
        n_arg      = 2'd2;
        with_index = 1'b1;
      end
      addr_mode_pkg::mode_ind_short: begin
        n_ptr = 2'd1;
      end
      addr_mode_pkg::mode_ind_long: begin
        n_ptr = 2'd2;
      end
      addr_mode_pkg::mode_indidx_short: begin
        n_ptr      = 2'd1;
        with_index = 1'b1;
      end
      addr_mode_pkg::mode_indidx_long: begin
        n_ptr      = 2'd2;
        with_index = 1'b1;
      end
      addr_mode_pkg::mode_rel_indirect, addr_mode_pkg::mode_bit_indirect: begin
        n_ptr = 2'd1;
      end
      addr_mode_pkg::mode_bit_dir_rel: begin
        with_disp = 1'b1;
      end
      default: begin
        n_arg = 2'd1;
      end
    endcase
  end

  always_comb begin
    total_len  = n_arg + {1'b0, with_disp};
    after_arg  = s.pc + addr_mode_pkg::addr_step + {14'h0000, n_arg};
    next_pc    = s.pc + addr_mode_pkg::addr_step + {14'h0000, total_len};
    base       = (n_ptr != 2'd0) ? s.ptr : s.arg;
    if (s.mode == addr_mode_pkg::mode_idx_none) begin
      base = 16'h0000;
    end
    index_term = with_index ?
                 {addr_mode_pkg::page_zero_hi, s.idx} : 16'h0000;
    rel_byte   = with_disp ? s.disp :
                 ((n_ptr != 2'd0) ? s.ptr[7:0] : s.arg[7:0]);
  end

  // ==========================================================
  // Sequencer
  always_comb begin
    next_s      = s;
    next_s.done = 1'b0;
    case (s.phase)
      st_idle: begin
        if (start) begin
          next_s.mode = mapped_mode;
          next_s.idx  = mapped_use_y ? req.index_y : req.index_x;
          next_s.pc   = req.program_counter;
          next_s.cnt  = 2'd0;
          next_s.arg  = 16'h0000;
          next_s.ptr  = 16'h0000;
          next_s.disp = 8'h00;
          next_s.busy = 1'b1;
          // long forms refused for read-modify-write operations
          if (req.rmw && addr_mode_pkg::is_long(mapped_mode)) begin
            next_s.res         = '0;
            next_s.res.refused = 1'b1;
            next_s.done        = 1'b1;
            next_s.busy        = 1'b0;
          end else if (addr_mode_pkg::arg_bytes(mapped_mode) == 2'd0) begin
            next_s.phase = st_done;
          end else begin
            next_s.phase    = st_arg;
            next_s.mem_req  = 1'b1;
            next_s.mem_addr = req.program_counter + addr_mode_pkg::addr_step;
          end
        end
      end
      st_arg: begin
        if (mem_ack) begin
          // short address byte; word high byte first
          next_s.arg = {s.arg[7:0], mem_rdata};
          if (s.cnt + 2'd1 == n_arg) begin
            next_s.cnt = 2'd0;
            if (n_ptr != 2'd0) begin
              // pointer address lies in page zero
              next_s.phase    = st_ptr;
              next_s.mem_addr = {addr_mode_pkg::page_zero_hi, mem_rdata};
            end else if (addr_mode_pkg::has_disp(s.mode)) begin
              next_s.phase    = st_disp;
              next_s.mem_addr = after_arg;
            end else begin
              next_s.phase   = st_done;
              next_s.mem_req = 1'b0;
            end
          end else begin
            next_s.cnt      = s.cnt + 2'd1;
            next_s.mem_addr = s.mem_addr + addr_mode_pkg::addr_step;
          end
        end
      end
      st_ptr: begin
        if (mem_ack) begin
          next_s.ptr = {s.ptr[7:0], mem_rdata};
          if (s.cnt + 2'd1 == n_ptr) begin
            next_s.cnt     = 2'd0;
            next_s.phase   = st_done;
            next_s.mem_req = 1'b0;
          end else begin
            next_s.cnt      = s.cnt + 2'd1;
            next_s.mem_addr = s.mem_addr + addr_mode_pkg::addr_step;
          end
        end
      end
      st_disp: begin
        if (mem_ack) begin
          next_s.disp    = mem_rdata;
          next_s.phase   = st_done;
          next_s.mem_req = 1'b0;
        end
      end
      st_done: begin
        next_s.phase       = st_idle;
        next_s.busy        = 1'b0;
        next_s.done        = 1'b1;
        next_s.res.refused = 1'b0;
        next_s.res.length  = total_len;
        next_s.res.operand = 8'h00;
        next_s.res.target  = 16'h0000;
        next_s.res.ea      = base + index_term;
        case (s.mode)
          addr_mode_pkg::mode_immediate: begin
            next_s.res.operand = s.arg[7:0];
            next_s.res.ea      = s.pc + addr_mode_pkg::addr_step;
          end
          addr_mode_pkg::mode_ind_short, addr_mode_pkg::mode_ind_long: begin
            next_s.res.ea = s.ptr;
          end
          addr_mode_pkg::mode_rel_direct, addr_mode_pkg::mode_rel_indirect,
          addr_mode_pkg::mode_bit_dir_rel: begin
            next_s.res.target = next_pc + {{8{rel_byte[7]}}, rel_byte};
            if (s.mode != addr_mode_pkg::mode_bit_dir_rel) begin
              next_s.res.ea = 16'h0000;
            end
          end
          default: begin
            next_s.res.operand = 8'h00;
          end
        endcase
      end
      default: begin
        next_s = '0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Outputs
  assign busy     = s.busy;
  assign done     = s.done;
  assign res      = s.res;
  assign mem_req  = s.mem_req;
  assign mem_addr = s.mem_addr;

endmodule

//--- tb/addr_mem_model.sv
// Program and data memory on the CPU bus, answering reads after a set lag.
// Assumes the unit holds mem_req and mem_addr until a one-cycle mem_ack.
`timescale 1ns/10ps

module addr_mem_model (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        mem_req,
  input  wire logic [15:0] mem_addr,
  input  wire logic [1:0]  lag,
  output logic [7:0]       mem_rdata,
  output logic             mem_ack
);
  logic [1:0] wait_cnt;

  // Content is a fixed scramble of the byte address
  function automatic logic [7:0] byte_at(input logic [15:0] a);
    return {a[3:0], a[7:4]} ^ a[15:8] ^ 8'h6c;
  endfunction

  // Data is only valid in the acknowledge cycle; inverted afterwards
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mem_ack <= 1'b0;
      mem_rdata <= 8'h00;
      wait_cnt <= 2'h0;
    end else if (mem_ack) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end else if (mem_req && wait_cnt >= lag) begin
      mem_ack <= 1'b1;
      mem_rdata <= byte_at(mem_addr);
      wait_cnt <= 2'h0;
    end else if (mem_req) begin
      wait_cnt <= wait_cnt + 2'h1;
    end
  end
endmodule

//--- tb/addr_mode_unit_assertions.sv
// Port checker of the operand addressing unit.
// Assumes one clock domain; bound to every instance of the unit.
`timescale 1ns/10ps

module addr_mode_unit_assertions (
  input wire logic                     clk,
  input wire logic                     resetn,
  input wire logic                     start,
  input wire addr_mode_pkg::addr_req_t req,
  input wire logic                     busy,
  input wire logic                     done,
  input wire addr_mode_pkg::addr_res_t res,
  input wire logic                     mem_req,
  input wire logic [15:0]              mem_addr,
  input wire logic [7:0]               mem_rdata,
  input wire logic                     mem_ack
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  addr_mode_pkg::addr_mode_t cap_mode;
  logic                      cap_pv;
  logic [15:0]               cap_pc;
  logic [7:0]                cap_x;
  logic [7:0]                b1;

  // ==========================================================
  // Request capture and first operand byte
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cap_mode <= addr_mode_pkg::mode_inherent;
      cap_pv <= 1'b0;
      cap_pc <= 16'h0000;
      cap_x <= 8'h00;
      b1 <= 8'h00;
    end else begin
      if (start && !busy && !done) begin
        cap_mode <= req.mode;
        cap_pv <= req.prefix_valid;
        cap_pc <= req.program_counter;
        cap_x <= req.index_x;
      end
      if (mem_ack && mem_req && mem_addr == cap_pc + 16'h0001) begin
        b1 <= mem_rdata;
      end
    end
  end

  // ==========================================================
  // Properties
  sequence s_go_inh;
    start && !busy && !done && !req.prefix_valid &&
      req.mode == addr_mode_pkg::mode_inherent;
  endsequence
  sequence s_go_rmw;
    start && !busy && !done && !req.prefix_valid && req.rmw &&
      req.mode == addr_mode_pkg::mode_dir_long;
  endsequence

  property p_inherent;
    s_go_inh |=> !mem_req ##1 (done && res.length == 2'h0);
  endproperty
  property p_immediate;
    done && cap_mode == addr_mode_pkg::mode_immediate
      |-> res.ea == cap_pc + 16'h0001 && res.operand == b1;
  endproperty
  property p_dir_short;
    done && cap_mode == addr_mode_pkg::mode_dir_short && !cap_pv
      |-> res.ea == {8'h00, b1};
  endproperty
  property p_long_word;
    mem_ack && mem_addr == cap_pc + 16'h0001 && !cap_pv &&
      cap_mode == addr_mode_pkg::mode_dir_long
      |=> mem_req && mem_addr == cap_pc + 16'h0002;
  endproperty
  property p_idx_none;
    done && cap_mode == addr_mode_pkg::mode_idx_none && !cap_pv
      |-> res.ea == {8'h00, cap_x};
  endproperty
  property p_idx_short;
    done && cap_mode == addr_mode_pkg::mode_idx_short && !cap_pv
      |-> res.ea == {8'h00, b1} + {8'h00, cap_x};
  endproperty
  property p_indidx_short;
    done && cap_mode == addr_mode_pkg::mode_indidx_short && !cap_pv
      |-> res.ea <= 16'h01fe && res.length == 2'h1;
  endproperty
  property p_refuse;
    s_go_rmw |=> done && res.refused && !mem_req;
  endproperty
  property p_rel;
    done && cap_mode == addr_mode_pkg::mode_rel_direct && !cap_pv
      |-> res.target == cap_pc + 16'h0002 + {{8{b1[7]}}, b1};
  endproperty

  a_inherent:
    assert property (p_inherent) else $error("inherent form fetched or took too long");
  a_immediate:
    assert property (p_immediate) else $error("immediate operand or address wrong");
  a_dir_short:
    assert property (p_dir_short) else $error("short direct address not in page zero");
  a_long_word:
    assert property (p_long_word) else $error("address word not read from consecutive bytes");
  a_idx_none:
    assert property (p_idx_none) else $error("indexed without offset address wrong");
  a_idx_short:
    assert property (p_idx_short) else $error("short indexed sum wrong");
  a_indidx_short:
    assert property (p_indidx_short) else $error("short indirect indexed out of range");
  a_refuse:
    assert property (p_refuse) else $error("long read-modify-write not refused");
  a_rel:
    assert property (p_rel) else $error("relative target wrong");
endmodule

bind addr_mode_unit addr_mode_unit_assertions chk_u (
  .clk(clk), .resetn(resetn), .start(start), .req(req), .busy(busy), .done(done),
  .res(res), .mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
  .mem_ack(mem_ack)
);

//--- tb/cpu_addressing_mode_decoder_tb.sv
// Self-checking bench of the operand addressing unit against a reference model.
// Assumes the memory model of this folder and the checker bound to the unit.
`timescale 1ns/10ps

module cpu_addressing_mode_decoder_tb;
  logic                     clk;
  logic                     resetn;
  logic                     start;
  addr_mode_pkg::addr_req_t req;
  addr_mode_pkg::addr_req_t r;
  logic                     busy;
  logic                     done;
  addr_mode_pkg::addr_res_t res;
  logic                     mem_req;
  logic [15:0]              mem_addr;
  logic [7:0]               mem_rdata;
  logic                     mem_ack;
  logic [1:0]               lag;
  logic [15:0]              seed;
  int                       bad_count = 0;
  int                       n_compared = 0;
  int                       cycles = 0;
  // Mode codes in enum order; prefix 92 converts to the indirect form
  int conv92[16] = '{0, 1, 7, 8, 4, 9, 10, 7, 8, 9, 10, 12, 12, 14, 14, 15};

  addr_mode_unit dut_u (.clk(clk), .resetn(resetn), .start(start), .req(req), .busy(busy),
    .done(done), .res(res), .mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack));
  addr_mem_model mem_u (.clk(clk), .resetn(resetn), .mem_req(mem_req), .mem_addr(mem_addr),
    .lag(lag), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [15:0] sx(input logic [7:0] d);
    return {{8{d[7]}}, d};
  endfunction

  // ==========================================================
  // Reference model of one request
  function automatic addr_mode_pkg::addr_res_t model(input addr_mode_pkg::addr_req_t q);
    addr_mode_pkg::addr_res_t e;
    int m, na, np;
    logic y;
    logic [15:0] pc, a, p, pa, idx;
    e = '0;
    m = int'(q.mode);
    pc = q.program_counter;
    y = q.prefix_valid && q.prefix == 8'h90;
    if (q.prefix_valid && q.prefix == 8'h92) m = conv92[m];
    if (q.prefix_valid && q.prefix == 8'h91 && (m == 5 || m == 6)) begin
      m = m + 4;
      y = 1'b1;
    end
    if (q.rmw && (m == 3 || m == 6 || m == 8 || m == 10)) begin
      e.refused = 1'b1;
      return e;
    end
    na = (m == 0 || m == 4) ? 0 : (m == 3 || m == 6) ? 2 : 1;
    np = (m == 7 || m == 9 || m == 12 || m == 14) ? 1 : (m == 8 || m == 10) ? 2 : 0;
    a = (na == 0) ? 16'h0000 : {8'h00, mem_u.byte_at(pc + 16'h0001)};
    if (na == 2) a = {a[7:0], mem_u.byte_at(pc + 16'h0002)};
    pa = {8'h00, a[7:0]};
    p = {8'h00, mem_u.byte_at(pa)};
    if (np == 2) p = {p[7:0], mem_u.byte_at(pa + 16'h0001)};
    idx = {8'h00, y ? q.index_y : q.index_x};
    e.length = 2'(na + int'(m == 15));
    e.ea = ((np > 0) ? p : a) + ((m == 4 || m == 5 || m == 6 || m == 9 || m == 10) ? idx : 16'h0);
    if (m == 1) begin
      e.operand = a[7:0];
      e.ea = pc + 16'h0001;
    end
    if (m == 11 || m == 12) begin
      e.target = pc + 16'h0001 + 16'(e.length) + sx((m == 11) ? a[7:0] : p[7:0]);
      e.ea = 16'h0000;
    end
    if (m == 15) e.target = pc + 16'h0003 + sx(mem_u.byte_at(pc + 16'h0002));
    return e;
  endfunction

  // ==========================================================
  // Comparison, request and closing tasks
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic run_one(input addr_mode_pkg::addr_req_t q);
    addr_mode_pkg::addr_res_t e;
    int k;
    e = model(q);
    @(posedge clk);
    #2;
    start = 1'b1;
    req = q;
    for (k = 0; k < 80; k++) begin
      @(posedge clk);
      #2;
      if (done === 1'b1) break;
      seed = lfsr_next(seed);
      start = busy & seed[0];
      req = addr_mode_pkg::addr_req_t'(~q);
    end
    start = 1'b0;
    check(64'({done, busy, res}), 64'({1'b1, 1'b0, e}));
  endtask

  task automatic results;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 12000) begin
      bad_count++;
      results();
    end
  end

  // ==========================================================
  // Main sequence: every mode under every prefix, then reset mid-run
  initial begin
    resetn = 1'b0;
    start = 1'b0;
    req = '0;
    r = '0;
    lag = 2'h0;
    seed = 16'h173b;
    repeat (8) @(posedge clk);
    #2;
    resetn = 1'b1;
    for (int pass = 0; pass < 2; pass++) begin
      for (int m = 0; m < 16; m++) begin
        for (int p = 0; p < 4; p++) begin
          seed = lfsr_next(seed);
          r.mode = addr_mode_pkg::addr_mode_t'(m);
          r.prefix = (p == 1) ? 8'h90 : (p == 2) ? 8'h92 : (p == 3) ? 8'h91 : seed[15:8];
          r.prefix_valid = (p != 0);
          r.rmw = (p == 0) ? (pass == 1) : seed[3];
          r.program_counter = seed ^ 16'h5a3c;
          r.index_x = pass ? 8'hff : seed[11:4];
          r.index_y = pass ? 8'hfe : seed[12:5];
          lag = seed[1:0];
          run_one(r);
        end
      end
    end
    r.mode = addr_mode_pkg::mode_ind_long;
    r.rmw = 1'b0;
    lag = 2'h3;
    @(posedge clk);
    #2;
    start = 1'b1;
    req = r;
    @(posedge clk);
    #2;
    start = 1'b0;
    repeat (3) @(posedge clk);
    #2;
    resetn = 1'b0;
    #3;
    check(64'({busy, done, mem_req, res}), 64'h0);
    repeat (2) @(posedge clk);
    #2;
    resetn = 1'b1;
    run_one(r);
    results();
  end
endmodule
